//--- dbe_top.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dbe_cfg.svh"
// How it works
// RULE_01: Instruction address matching compare setup raises instruction match event.
// RULE_02: Load, store or cache op matching data compare raises data address event.
// RULE_03: Data address match plus equal data value raises data value event.
// RULE_04: Only taken branches raise branch event.
// RULE_05: Trap-word with true condition raises trap event.
// RULE_06: Any of three return-from-interrupt instructions raises exit event.
// RULE_07: Each successfully completed instruction raises complete event.
// RULE_08: Every interrupt generated raises interrupt event.
// RULE_09: Debug tool request raises unconditional event without enable.
// RULE_10: Other events gated by control zero enables; all recorded in status.
// RULE_11: Four compare addresses, exact or paired as two ranges.
// RULE_12: Each compare event needs its enable and sets its status bit.
// RULE_13: Mode 00 fires each comparator on exact address equality.
// RULE_14: Mode 10 matches lower <= address < upper.
// RULE_15: Mode 11 matches address < lower or address >= upper.
// RULE_16: Range match sets status bits of enabled halves of the pair.
// RULE_17: Mode 01 is reserved.
// RULE_18: Privilege selector: 00 any, 10 supervisor, 11 user, 01 reserved.
// RULE_19: Software programs both privilege selectors of a range pair equal.
// RULE_20: Space selector: 00 any, 10 space 0, 11 space 1.
// RULE_21: Process identifier is ignored; only address and space bit compare.
// RULE_22: Space selector 01 is reserved.
// RULE_23: Software enables at least one event of a pair in range mode.
// RULE_24: Auto-toggle with toggle state set swaps modes 10 and 11.
// RULE_25: Auto-toggle flips toggle state with each pair event, same update.
// RULE_26: Reserved selector or mode values produce no event.
module dbe_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic insn_valid,
  input wire logic [31:0] insn_addr,
  input wire logic user_mode_bit,
  input wire logic insn_space_bit,
  input wire logic insn_complete,
  input wire logic branch_taken,
  input wire logic trap_word_insn,
  input wire logic trap_cond_true,
  input wire logic handler_exit,
  input wire logic interrupt_taken,
  input wire logic data_access,
  input wire logic [31:0] data_addr,
  input wire logic [31:0] data_value,
  input wire logic unconditional_req,
  output logic [31:0] debug_status_out,
  output logic event_pulse
);
  import dbe_pkg::*;

  logic [31:0] debug_ctrl_zero_reg;
  logic [31:0] debug_ctrl_one_reg;
  logic [31:0] debug_status_reg;
  logic [31:0] debug_status_next;
  logic [31:0] insn_cmp_addr_one_reg;
  logic [31:0] insn_cmp_addr_two_reg;
  logic [31:0] insn_cmp_addr_three_reg;
  logic [31:0] insn_cmp_addr_four_reg;
  logic [31:0] data_cmp_addr_one_reg;
  logic [31:0] data_cmp_addr_two_reg;
  logic [31:0] data_value_one_reg;
  logic [31:0] data_value_two_reg;
  logic [31:0] prdata_reg;
  logic event_pulse_reg;
  logic [3:0] qual_pass;
  logic [3:0] cmp_hit;
  logic [3:0] insn_addr_match;
  logic [1:0] data_addr_hit;
  logic [1:0] data_value_hit;
  logic [13:0] events;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] wmask;
  dbe_apb_state_t apb_state_reg;
  dbe_apb_state_t apb_state_next;

  assign wr_en = (apb_state_reg == DBE_ST_SETUP) && psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign debug_status_out = debug_status_reg;
  assign event_pulse = event_pulse_reg;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb
  begin
    addr_ok = 1'b1;
    if (paddr == `DBE_OFF_CTRL_ZERO)
      addr_ok = 1'b1;
    else if (paddr == `DBE_OFF_CTRL_ONE)
      addr_ok = 1'b1;
    else if (paddr == `DBE_OFF_STATUS)
      addr_ok = 1'b1;
    else if (paddr >= `DBE_OFF_CMP_ADDR_ONE && paddr <= `DBE_OFF_DATA_VALUE_TWO
             && paddr[1:0] == 2'h0)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  end
  assign pslverr = psel && penable && !addr_ok;

  // A write lands once per transfer, even if a master stretches its access phase.
  always_comb
  begin
    apb_state_next = DBE_ST_IDLE;
    case (apb_state_reg)
      DBE_ST_IDLE:
        if (psel && !penable)
          apb_state_next = DBE_ST_SETUP;
      DBE_ST_SETUP:
        if (psel && penable)
          apb_state_next = DBE_ST_ACCESS;
        else if (psel)
          apb_state_next = DBE_ST_SETUP;
      DBE_ST_ACCESS:
        if (psel && !penable)
          apb_state_next = DBE_ST_SETUP;
      default:
        apb_state_next = DBE_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apb_state_reg <= DBE_ST_IDLE;
    else
      apb_state_reg <= apb_state_next;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_qual
      dbe_qual u_qual (
        .priv_sel(debug_ctrl_one_reg[`DBE_C1_PRIV + 2*gi +: 2]),
        .space_sel(debug_ctrl_one_reg[`DBE_C1_SPACE + 2*gi +: 2]),
        .user_mode_bit(user_mode_bit),
        .insn_space_bit(insn_space_bit),
        .pass(qual_pass[gi])
      );
    end
  endgenerate

  dbe_pair u_pair_a (
    .addr(insn_addr),
    .cmp_lo(insn_cmp_addr_one_reg),
    .cmp_hi(insn_cmp_addr_two_reg),
    .mode(debug_ctrl_one_reg[`DBE_C1_MODE_A +: 2]),
    .autotoggle_en(debug_ctrl_one_reg[`DBE_C1_AT_A]),
    .toggle_state(debug_status_reg[`DBE_ST_TOGGLE_A]),
    .qual_pass(qual_pass[1:0]),
    .hit(cmp_hit[1:0])
  );

  dbe_pair u_pair_b (
    .addr(insn_addr),
    .cmp_lo(insn_cmp_addr_three_reg),
    .cmp_hi(insn_cmp_addr_four_reg),
    .mode(debug_ctrl_one_reg[`DBE_C1_MODE_B +: 2]),
    .autotoggle_en(debug_ctrl_one_reg[`DBE_C1_AT_B]),
    .toggle_state(debug_status_reg[`DBE_ST_TOGGLE_B]),
    .qual_pass(qual_pass[3:2]),
    .hit(cmp_hit[3:2])
  );

  // Data comparators are exact matches on either address register.
  assign data_addr_hit[0] = data_access && (data_addr == data_cmp_addr_one_reg);
  assign data_addr_hit[1] = data_access && (data_addr == data_cmp_addr_two_reg);
  assign data_value_hit[0] = data_addr_hit[0] && (data_value == data_value_one_reg);
  assign data_value_hit[1] = data_addr_hit[1] && (data_value == data_value_two_reg);

  always_comb
  begin
    insn_addr_match = {4{insn_valid}} & cmp_hit
                      & debug_ctrl_zero_reg[`DBE_EN_INSN_CMP +: 4]; // [RULE_01] [RULE_11] [RULE_12]
    events = 14'h0;
    events[3:0] = insn_addr_match;
    events[`DBE_EN_DATA_ADDR] = (|data_addr_hit)
                                && debug_ctrl_zero_reg[`DBE_EN_DATA_ADDR]; // [RULE_02] [RULE_10]
    events[`DBE_EN_DATA_VALUE] = (|data_value_hit)
                                 && debug_ctrl_zero_reg[`DBE_EN_DATA_VALUE]; // [RULE_03]
    events[`DBE_EN_BRANCH] = insn_valid && branch_taken
                             && debug_ctrl_zero_reg[`DBE_EN_BRANCH]; // [RULE_04]
    events[`DBE_EN_TRAP] = insn_valid && trap_word_insn && trap_cond_true
                           && debug_ctrl_zero_reg[`DBE_EN_TRAP]; // [RULE_05]
    events[`DBE_EN_RET] = insn_valid && handler_exit
                          && debug_ctrl_zero_reg[`DBE_EN_RET]; // [RULE_06]
    events[`DBE_EN_INSN_COMPLETE_EVENT] = insn_complete && debug_ctrl_zero_reg[`DBE_EN_INSN_COMPLETE_EVENT]; // [RULE_07]
    events[`DBE_EN_INTERRUPT_EVENT] = interrupt_taken && debug_ctrl_zero_reg[`DBE_EN_INTERRUPT_EVENT]; // [RULE_08]
    events[`DBE_ST_UNCOND] = unconditional_req; // [RULE_09]
  end

  // Software clears status bits by writing ones; a new event in the same cycle wins.
  always_comb
  begin
    debug_status_next = debug_status_reg;
    if (wr_en && paddr == `DBE_OFF_STATUS)
      debug_status_next = debug_status_reg & ~(pwdata & wmask);
    debug_status_next[11:0] = debug_status_next[11:0] | events[11:0]; // [RULE_10]
    if (debug_ctrl_one_reg[`DBE_C1_AT_A] && |insn_addr_match[1:0])
      debug_status_next[`DBE_ST_TOGGLE_A] = !debug_status_reg[`DBE_ST_TOGGLE_A]; // [RULE_25]
    if (debug_ctrl_one_reg[`DBE_C1_AT_B] && |insn_addr_match[3:2])
      debug_status_next[`DBE_ST_TOGGLE_B] = !debug_status_reg[`DBE_ST_TOGGLE_B]; // [RULE_25]
    debug_status_next[31:14] = 18'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_status_reg <= `DBE_STATUS_RESET;
    else
      debug_status_reg <= debug_status_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_pulse_reg <= 1'b0;
    else
      event_pulse_reg <= |events[11:0];
  end

  // Unused enable bits are held at zero so a read shows only real enables.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_ctrl_zero_reg <= `DBE_CTRL_ZERO_RESET;
    else if (wr_en && paddr == `DBE_OFF_CTRL_ZERO)
      debug_ctrl_zero_reg <= ((debug_ctrl_zero_reg & ~wmask) | (pwdata & wmask))
                             & `DBE_CTRL_ZERO_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_ctrl_one_reg <= `DBE_CTRL_ONE_RESET;
    else if (wr_en && paddr == `DBE_OFF_CTRL_ONE)
      debug_ctrl_one_reg <= (debug_ctrl_one_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      insn_cmp_addr_one_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_CMP_ADDR_ONE)
      insn_cmp_addr_one_reg <= (insn_cmp_addr_one_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      insn_cmp_addr_two_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_CMP_ADDR_TWO)
      insn_cmp_addr_two_reg <= (insn_cmp_addr_two_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      insn_cmp_addr_three_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_CMP_ADDR_THREE)
      insn_cmp_addr_three_reg <= (insn_cmp_addr_three_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      insn_cmp_addr_four_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_CMP_ADDR_FOUR)
      insn_cmp_addr_four_reg <= (insn_cmp_addr_four_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_cmp_addr_one_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_DATA_ADDR_ONE)
      data_cmp_addr_one_reg <= (data_cmp_addr_one_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_cmp_addr_two_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_DATA_ADDR_TWO)
      data_cmp_addr_two_reg <= (data_cmp_addr_two_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_value_one_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_DATA_VALUE_ONE)
      data_value_one_reg <= (data_value_one_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_value_two_reg <= `DBE_ADDR_RESET;
    else if (wr_en && paddr == `DBE_OFF_DATA_VALUE_TWO)
      data_value_two_reg <= (data_value_two_reg & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0;
    else if (rd_en)
    begin
      if (paddr == `DBE_OFF_CTRL_ZERO)
        prdata_reg <= debug_ctrl_zero_reg;
      else if (paddr == `DBE_OFF_CTRL_ONE)
        prdata_reg <= debug_ctrl_one_reg;
      else if (paddr == `DBE_OFF_STATUS)
        prdata_reg <= debug_status_reg;
      else if (paddr == `DBE_OFF_CMP_ADDR_ONE)
        prdata_reg <= insn_cmp_addr_one_reg;
      else if (paddr == `DBE_OFF_CMP_ADDR_TWO)
        prdata_reg <= insn_cmp_addr_two_reg;
      else if (paddr == `DBE_OFF_CMP_ADDR_THREE)
        prdata_reg <= insn_cmp_addr_three_reg;
      else if (paddr == `DBE_OFF_CMP_ADDR_FOUR)
        prdata_reg <= insn_cmp_addr_four_reg;
      else if (paddr == `DBE_OFF_DATA_ADDR_ONE)
        prdata_reg <= data_cmp_addr_one_reg;
      else if (paddr == `DBE_OFF_DATA_ADDR_TWO)
        prdata_reg <= data_cmp_addr_two_reg;
      else if (paddr == `DBE_OFF_DATA_VALUE_ONE)
        prdata_reg <= data_value_one_reg;
      else if (paddr == `DBE_OFF_DATA_VALUE_TWO)
        prdata_reg <= data_value_two_reg;
      else
        prdata_reg <= 32'h0;
    end
  end
  // Status is sampled in the setup cycle, so a read shows it one cycle old.
endmodule : dbe_top
`default_nettype wire

//--- dbe_cfg.svh
`ifndef DBE_CFG_SVH
`define DBE_CFG_SVH
`define DBE_OFF_CTRL_ZERO 12'h000
`define DBE_OFF_CTRL_ONE 12'h004
`define DBE_OFF_STATUS 12'h008
`define DBE_OFF_CMP_ADDR_ONE 12'h010
`define DBE_OFF_CMP_ADDR_TWO 12'h014
`define DBE_OFF_CMP_ADDR_THREE 12'h018
`define DBE_OFF_CMP_ADDR_FOUR 12'h01c
`define DBE_OFF_DATA_ADDR_ONE 12'h020
`define DBE_OFF_DATA_ADDR_TWO 12'h024
`define DBE_OFF_DATA_VALUE_ONE 12'h028
`define DBE_OFF_DATA_VALUE_TWO 12'h02c
`define DBE_CTRL_ZERO_RESET 32'h0000_0000
`define DBE_CTRL_ONE_RESET 32'h0000_0000
`define DBE_STATUS_RESET 32'h0000_0000
`define DBE_ADDR_RESET 32'h0000_0000
`define DBE_CTRL_ZERO_MASK 32'h0000_07ff
`define DBE_EN_INSN_CMP 0
`define DBE_EN_DATA_ADDR 4
`define DBE_EN_DATA_VALUE 5
`define DBE_EN_BRANCH 6
`define DBE_EN_TRAP 7
`define DBE_EN_RET 8
`define DBE_EN_INSN_COMPLETE_EVENT 9
`define DBE_EN_INTERRUPT_EVENT 10
`define DBE_ST_UNCOND 11
`define DBE_ST_TOGGLE_A 12
`define DBE_ST_TOGGLE_B 13
`define DBE_C1_MODE_A 0
`define DBE_C1_MODE_B 2
`define DBE_C1_AT_A 4
`define DBE_C1_AT_B 5
`define DBE_C1_PRIV 8
`define DBE_C1_SPACE 16
`endif

//--- dbe_pkg.sv
package dbe_pkg;
  typedef enum logic [1:0] {
    DBE_MODE_EXACT = 2'h0,
    DBE_MODE_RSVD = 2'h1,
    DBE_MODE_INCL = 2'h2,
    DBE_MODE_EXCL = 2'h3
  } dbe_mode_t;
  typedef enum logic [2:0] {
    DBE_ST_IDLE = 3'h1,
    DBE_ST_SETUP = 3'h2,
    DBE_ST_ACCESS = 3'h4
  } dbe_apb_state_t;
endpackage : dbe_pkg

//--- dbe_qual.sv
`timescale 1ns/1ps
`default_nettype none
module dbe_qual (
  input wire logic [1:0] priv_sel,
  input wire logic [1:0] space_sel,
  input wire logic user_mode_bit,
  input wire logic insn_space_bit,
  output logic pass
);
  // The process identifier is never consulted, only the space bit.
  always_comb
  begin
    pass = 1'b1;
    if (priv_sel == 2'h1)
      pass = 1'b0; // [RULE_26]
    else if (priv_sel[1] && (priv_sel[0] != user_mode_bit))
      pass = 1'b0; // [RULE_18]
    if (space_sel == 2'h1)
      pass = 1'b0; // [RULE_22]
    else if (space_sel[1] && (space_sel[0] != insn_space_bit))
      pass = 1'b0; // [RULE_20] [RULE_21]
  end
endmodule : dbe_qual
`default_nettype wire

//--- dbe_pair.sv
`timescale 1ns/1ps
`default_nettype none
module dbe_pair
  import dbe_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic [31:0] cmp_lo,
  input wire logic [31:0] cmp_hi,
  input wire logic [1:0] mode,
  input wire logic autotoggle_en,
  input wire logic toggle_state,
  input wire logic [1:0] qual_pass,
  output logic [1:0] hit
);
  logic in_range;
  logic excl;
  assign in_range = (addr >= cmp_lo) && (addr < cmp_hi);
  assign excl = mode[0] ^ (autotoggle_en & toggle_state); // [RULE_24]
  always_comb
  begin
    hit = 2'h0;
    case (mode)
      DBE_MODE_EXACT:
        hit = {addr == cmp_hi, addr == cmp_lo} & qual_pass; // [RULE_13]
      DBE_MODE_INCL, DBE_MODE_EXCL:
        // Both halves see the same range result, each masked by its own qualifier; the enables pick which record it.
        hit = {2{in_range ^ excl}} & qual_pass; // [RULE_14] [RULE_15] [RULE_16]
      default:
        hit = 2'h0; // [RULE_17] [RULE_26]
    endcase
  end
endmodule : dbe_pair
`default_nettype wire

//--- dbe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dbe_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic insn_valid,
  input wire logic [31:0] insn_addr,
  input wire logic branch_taken,
  input wire logic trap_word_insn,
  input wire logic trap_cond_true,
  input wire logic handler_exit,
  input wire logic insn_complete,
  input wire logic interrupt_taken,
  input wire logic unconditional_req,
  input wire logic [31:0] debug_status_out,
  input wire logic event_pulse
);
  logic [31:0] en_reg;
  logic [31:0] c1_reg;
  logic [31:0] a1_reg;
  wire logic wr = psel && penable && pwrite;
  // Shadows of the control words tell which events are armed; full-word writes are assumed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg <= 32'h0;
      c1_reg <= 32'h0;
      a1_reg <= 32'h0;
    end
    else if (wr)
    begin
      if (paddr == 12'h000) en_reg <= pwdata;
      if (paddr == 12'h004) c1_reg <= pwdata;
      if (paddr == 12'h010) a1_reg <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_uncond; unconditional_req |-> ##[1:2] debug_status_out[11]; endproperty
  a_uncond: assert property (p_uncond)
    else $error("unconditional event not recorded");
  property p_pulse; unconditional_req |=> event_pulse; endproperty
  a_pulse: assert property (p_pulse)
    else $error("event pulse missing");
  property p_branch; insn_valid && branch_taken && en_reg[6] |-> ##[1:2] debug_status_out[6];
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch event not recorded");
  property p_trap;
    insn_valid && trap_word_insn && trap_cond_true && en_reg[7] |-> ##[1:2] debug_status_out[7];
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap event not recorded");
  property p_ret; insn_valid && handler_exit && en_reg[8] |-> ##[1:2] debug_status_out[8];
  endproperty
  a_ret: assert property (p_ret)
    else $error("return event not recorded");
  property p_insn_complete_event; insn_complete && en_reg[9] |-> ##[1:2] debug_status_out[9]; endproperty
  a_insn_complete_event: assert property (p_insn_complete_event)
    else $error("complete event not recorded");
  property p_interrupt_event; interrupt_taken && en_reg[10] |-> ##[1:2] debug_status_out[10]; endproperty
  a_interrupt_event: assert property (p_interrupt_event)
    else $error("interrupt event not recorded");
  property p_exact;
    insn_valid && en_reg[0] && c1_reg[1:0] == 2'h0 && c1_reg[9:8] == 2'h0 &&
    c1_reg[17:16] == 2'h0 && insn_addr == a1_reg |-> ##[1:2] debug_status_out[0];
  endproperty
  a_exact: assert property (p_exact)
    else $error("exact compare event not recorded");
endmodule : dbe_chk
bind dbe_top dbe_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .insn_valid(insn_valid),
  .insn_addr(insn_addr), .branch_taken(branch_taken), .trap_word_insn(trap_word_insn),
  .trap_cond_true(trap_cond_true), .handler_exit(handler_exit),
  .insn_complete(insn_complete), .interrupt_taken(interrupt_taken),
  .unconditional_req(unconditional_req), .debug_status_out(debug_status_out),
  .event_pulse(event_pulse));
`default_nettype wire

//--- dbe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbe_core_model (
  input wire logic pclk,
  output logic insn_valid,
  output logic branch_taken,
  output logic trap_word_insn,
  output logic trap_cond_true,
  output logic handler_exit,
  output logic insn_complete,
  output logic interrupt_taken,
  output logic data_access,
  output logic unconditional_req,
  output logic [31:0] insn_addr,
  output logic [31:0] data_addr,
  output logic [31:0] data_value,
  output logic user_mode_bit,
  output logic insn_space_bit
);
  logic [8:0] fl = 9'h000;
  logic [31:0] ad = 32'h0;
  logic [1:0] ms = 2'h0;
  assign {unconditional_req, data_access, interrupt_taken, insn_complete, handler_exit} = fl[8:4];
  assign {trap_cond_true, trap_word_insn, branch_taken, insn_valid} = fl[3:0];
  assign insn_addr = ad;
  assign data_addr = ad;
  assign data_value = ~ad;
  assign user_mode_bit = ms[1];
  assign insn_space_bit = ms[0];
  // One cycle of activity, then the side lines flip so stale values are never read as valid.
  task automatic step(input logic [8:0] f, input logic [31:0] a, input logic [1:0] us);
    @(posedge pclk);
    fl <= f;
    ad <= a;
    ms <= us;
    @(posedge pclk);
    fl <= 9'h000;
    ad <= ~a;
    ms <= ~us;
  endtask : step
endmodule : dbe_core_model
`default_nettype wire

//--- dbe_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin err_count++; $display("mismatch %s expected %h seen %h", nm, ex, sn); end end
module dbe_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_checks = 0;
  wire logic pready, pslverr, event_pulse, insn_valid, branch_taken, trap_word_insn;
  wire logic trap_cond_true, handler_exit, insn_complete, interrupt_taken, data_access;
  wire logic unconditional_req, user_mode_bit, insn_space_bit;
  wire logic [31:0] prdata, insn_addr, data_addr, data_value, debug_status_out;
  always #4 pclk = ~pclk;
  dbe_core_model core (.pclk, .insn_valid, .branch_taken, .trap_word_insn, .trap_cond_true,
    .handler_exit, .insn_complete, .interrupt_taken, .data_access, .unconditional_req,
    .insn_addr, .data_addr, .data_value, .user_mode_bit, .insn_space_bit);
  dbe_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .insn_valid, .insn_addr, .user_mode_bit, .insn_space_bit,
    .insn_complete, .branch_taken, .trap_word_insn, .trap_cond_true, .handler_exit,
    .interrupt_taken, .data_access, .data_addr, .data_value, .unconditional_req,
    .debug_status_out, .event_pulse);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50)
    begin
      err_count++;
      give_verdict;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t(input logic [31:0] en, input logic [31:0] c1, input logic [8:0] f,
    input logic [31:0] a, input logic [1:0] us, input logic [31:0] e);
    apb(1'b1, 12'h000, en);
    apb(1'b1, 12'h004, c1);
    apb(1'b1, 12'h008, 32'h0000_0fff);
    core.step(f, a, us);
    repeat (2) @(posedge pclk);
    `CHK("status out", e, debug_status_out)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("status", e, rd)
  endtask : t
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    for (int k = 0; k < 4; k++) apb(1'b1, 12'h010 + 12'(4 * k), 32'(k + 1) << 8);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'h010 + 12'(4 * k), 32'h0);
      `CHK("compare address", 32'(k + 1) << 8, rd)
    end
    apb(1'b1, 12'h020, 32'h500);
    apb(1'b1, 12'h028, 32'hffff_faff);
    t(32'h0, 32'h0, 9'h100, 32'h0, 2'h0, 32'h800);
    t(32'h0, 32'h0, 9'h063, 32'h0, 2'h0, 32'h0);
    t(32'h7f0, 32'h0, 9'h003, 32'h0, 2'h0, 32'h40);
    t(32'h7f0, 32'h0, 9'h001, 32'h0, 2'h0, 32'h0);
    t(32'h7f0, 32'h0, 9'h00d, 32'h0, 2'h0, 32'h80);
    t(32'h7f0, 32'h0, 9'h005, 32'h0, 2'h0, 32'h0);
    t(32'h7f0, 32'h0, 9'h011, 32'h0, 2'h0, 32'h100);
    t(32'h7f0, 32'h0, 9'h020, 32'h0, 2'h0, 32'h200);
    t(32'h7f0, 32'h0, 9'h040, 32'h0, 2'h0, 32'h400);
    t(32'h7f0, 32'h0, 9'h080, 32'h500, 2'h0, 32'h30);
    t(32'hf, 32'h0, 9'h001, 32'h100, 2'h0, 32'h1);
    t(32'hf, 32'h0, 9'h001, 32'h104, 2'h0, 32'h0);
    t(32'hf, 32'h0, 9'h001, 32'h400, 2'h0, 32'h8);
    t(32'he, 32'h0, 9'h001, 32'h100, 2'h0, 32'h0);
    t(32'hf, 32'h200, 9'h001, 32'h100, 2'h2, 32'h0);
    t(32'hf, 32'h200, 9'h001, 32'h100, 2'h0, 32'h1);
    t(32'hf, 32'h300, 9'h001, 32'h100, 2'h2, 32'h1);
    t(32'hf, 32'h100, 9'h001, 32'h100, 2'h0, 32'h0);
    t(32'hf, 32'h20000, 9'h001, 32'h100, 2'h1, 32'h0);
    t(32'hf, 32'h30000, 9'h001, 32'h100, 2'h1, 32'h1);
    t(32'hf, 32'h10000, 9'h001, 32'h100, 2'h0, 32'h0);
    t(32'h3, 32'h2, 9'h001, 32'h100, 2'h0, 32'h3);
    t(32'h3, 32'h2, 9'h001, 32'h1fc, 2'h0, 32'h3);
    t(32'h3, 32'h2, 9'h001, 32'h200, 2'h0, 32'h0);
    t(32'h3, 32'h2, 9'h001, 32'h0fc, 2'h0, 32'h0);
    t(32'h2, 32'h2, 9'h001, 32'h180, 2'h0, 32'h2);
    t(32'h1, 32'h3, 9'h001, 32'h0fc, 2'h0, 32'h1);
    t(32'h1, 32'h3, 9'h001, 32'h200, 2'h0, 32'h1);
    t(32'h1, 32'h3, 9'h001, 32'h1fc, 2'h0, 32'h0);
    t(32'h1, 32'h1, 9'h001, 32'h100, 2'h0, 32'h0);
    t(32'hc, 32'h8, 9'h001, 32'h300, 2'h0, 32'hc);
    t(32'h1, 32'h12, 9'h001, 32'h100, 2'h0, 32'h1001);
    t(32'h1, 32'h12, 9'h001, 32'h100, 2'h0, 32'h1000);
    t(32'h1, 32'h12, 9'h001, 32'h200, 2'h0, 32'h1);
    give_verdict;
  end
endmodule : dbe_top_tb_top
`default_nettype wire
